/* File: mgmt_event_nmi_reset_logger.sv */
// Purpose: Boot-store, forced-reset and interrupt event logger with event log
// Assumes: Commands arrive as one-cycle pulses from the management core
// Notes: Log array stands in for the serial non-volatile store
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_event_params.svh"
module mgmt_event_nmi_reset_logger #(
  parameter int NMI_CYCLES = `NMI_PULSE_CYCLES,
  parameter int LOG_DEPTH = `LOG_DEPTH_DEFAULT,
  parameter int QUEUE_DEPTH = `QUEUE_DEPTH_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Boot-store selection
  input wire logic boot_select_i,
  input wire logic [7:0] boot_cause_i,
  input wire logic boot_change_i,
  output logic [7:0] primary_offset_o,
  output logic [7:0] backup_offset_o,
  // Reset requests
  input wire logic reset_req_i,
  input wire logic reset_soft_i,
  input wire logic [7:0] reset_cause_i,
  input wire logic cpu_internal_error_i,
  input wire logic cpu_err_reset_cfg_i,
  input wire logic cpu_err_nmi_cfg_i,
  output logic host_reset_o,
  // Interrupt triggers and control
  input wire logic nmi_chassis_i,
  input wire logic nmi_filter_i,
  input wire logic nmi_pretimeout_i,
  input wire logic pretimeout_nmi_en_i,
  input wire logic nmi_set_source_i,
  input wire logic nmi_enable_cmd_i,
  input wire logic nmi_enable_val_i,
  input wire logic nmi_get_source_i,
  output mgmt_event_pkg::nmi_source_type nmi_source_o,
  output logic nmi_o,
  // Log access
  input wire logic add_entry_i,
  input wire mgmt_event_pkg::event_entry_type add_data_i,
  input wire logic reserve_i,
  input wire logic clear_i,
  input wire logic [15:0] read_index_i,
  output mgmt_event_pkg::event_entry_type read_data_o,
  output logic [15:0] entry_count_o,
  output logic log_full_o,
  output logic clearing_o,
  output logic queue_full_o,
  output logic forward_valid_o,
  output mgmt_event_pkg::event_entry_type forward_data_o
);
  import mgmt_event_pkg::*;

  localparam int LAW = $clog2(LOG_DEPTH);
  localparam int CW = $clog2(NMI_CYCLES + 1);

  // ---------------------------------------------------------------
  // Boot-store sensors
  // ---------------------------------------------------------------
  boot_store_type boot_store;
  logic boot_ev;
  event_entry_type boot_entry;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_store <= BOOT_PRIMARY;
    end else if (boot_change_i) begin
      boot_store <= boot_select_i ? BOOT_BACKUP : BOOT_PRIMARY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      primary_offset_o <= `OFFSET_SELECTED;
      backup_offset_o <= `OFFSET_UNSELECTED;
    end else begin
      primary_offset_o <= (boot_store == BOOT_PRIMARY) ? `OFFSET_SELECTED
                                                        : `OFFSET_UNSELECTED;
      backup_offset_o <= (boot_store == BOOT_BACKUP) ? `OFFSET_SELECTED
                                                      : `OFFSET_UNSELECTED;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_ev <= 1'b0;
      boot_entry <= '0;
    end else begin
      boot_ev <= boot_change_i;
      if (boot_change_i) begin
        // One entry is logged against the newly selected store's sensor
        boot_entry.sensor_num <= boot_select_i ? `BACKUP_SENSOR_NUM
                                               : `PRIMARY_SENSOR_NUM;
        boot_entry.sensor_type <= `OEM_SENSOR_TYPE;
        boot_entry.read_type <= `DISCRETE_READ_TYPE;
        boot_entry.offset <= `OFFSET_SELECTED;
        boot_entry.data2 <= boot_cause_i;
        boot_entry.data3 <= `NO_DATA_BYTE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Forced reset
  // ---------------------------------------------------------------
  logic cpu_err_d;
  logic cpu_err_rise;
  logic rst_ev;
  event_entry_type rst_entry;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_err_d <= 1'b0;
    end else begin
      cpu_err_d <= cpu_internal_error_i;
    end
  end
  assign cpu_err_rise = cpu_internal_error_i && !cpu_err_d;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_reset_o <= 1'b0;
      rst_ev <= 1'b0;
      rst_entry <= '0;
    end else begin
      host_reset_o <= reset_req_i || (cpu_err_rise && cpu_err_reset_cfg_i);
      // Entry follows assertion by one cycle so the log never precedes the reset
      rst_ev <= host_reset_o && !rst_ev;
      if (reset_req_i || (cpu_err_rise && cpu_err_reset_cfg_i)) begin
        rst_entry.sensor_num <= `RESET_SENSOR_NUM;
        rst_entry.sensor_type <= `RESET_SENSOR_TYPE;
        rst_entry.read_type <= `EVENT_ONLY_READ_TYPE;
        rst_entry.offset <= `OFFSET_ASSERTED;
        rst_entry.data2 <= reset_soft_i ? `RESET_TYPE_SOFT : `RESET_TYPE_HARD;
        // Caller supplies causes 01h-06h; CPU error overrides with its own code
        rst_entry.data3 <= (cpu_err_rise && cpu_err_reset_cfg_i) ? `RESET_CAUSE_CPU_ERR
                                                                 : reset_cause_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pulse
  // ---------------------------------------------------------------
  logic nmi_enabled;
  logic nmi_armed;
  logic [CW-1:0] nmi_count;
  logic nmi_trigger;
  logic [7:0] next_nmi_cause;
  nmi_source_type new_sources;
  logic nmi_ev;
  event_entry_type nmi_entry;

  always_comb begin
    new_sources.pretimeout = nmi_pretimeout_i && pretimeout_nmi_en_i;
    new_sources.filter = nmi_filter_i;
    new_sources.chassis = nmi_chassis_i;
    new_sources.cpu_err = cpu_err_rise && cpu_err_nmi_cfg_i;
    new_sources.external = nmi_set_source_i;
  end
  assign nmi_trigger = (|new_sources) && nmi_enabled && nmi_armed && !nmi_o;

  always_comb begin
    next_nmi_cause = `NMI_CAUSE_CHASSIS;
    if (new_sources.cpu_err) begin
      next_nmi_cause = `NMI_CAUSE_CPU_ERR;
    end else if (new_sources.pretimeout) begin
      next_nmi_cause = `NMI_CAUSE_PRETIMEOUT;
    end else if (new_sources.filter) begin
      next_nmi_cause = `NMI_CAUSE_FILTER;
    end
  end

  // Mask lives in plain flops so a power cycle restores enabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_enabled <= 1'b1;
    end else if (nmi_enable_cmd_i) begin
      nmi_enabled <= nmi_enable_val_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_armed <= 1'b1;
    end else if (nmi_trigger) begin
      nmi_armed <= 1'b0;
    end else if (nmi_enable_cmd_i && nmi_enable_val_i) begin
      nmi_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_count <= '0;
      nmi_o <= 1'b0;
    end else if (nmi_trigger) begin
      nmi_count <= CW'(NMI_CYCLES - 1);
      nmi_o <= 1'b1;
    end else if (nmi_count != '0) begin
      nmi_count <= nmi_count - 1'b1;
    end else begin
      nmi_o <= 1'b0;
    end
  end

  // Sources accumulate even while masked; read clears, a new set wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_source_o <= '0;
    end else if (nmi_get_source_i) begin
      nmi_source_o <= new_sources;
    end else begin
      nmi_source_o <= nmi_source_o | new_sources;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_ev <= 1'b0;
      nmi_entry <= '0;
    end else begin
      // Set-source alone has no cause code, so only coded causes are logged
      nmi_ev <= nmi_trigger && (|new_sources[4:1]);
      if (nmi_trigger) begin
        nmi_entry.sensor_num <= `NMI_SENSOR_NUM;
        nmi_entry.sensor_type <= `NMI_SENSOR_TYPE;
        nmi_entry.read_type <= `EVENT_ONLY_READ_TYPE;
        nmi_entry.offset <= `OFFSET_ASSERTED;
        nmi_entry.data2 <= next_nmi_cause;
        nmi_entry.data3 <= `NO_DATA_BYTE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Event merge into the queue
  // ---------------------------------------------------------------
  // Four sources may fire together; pending flags hold them until queued
  logic [3:0] pend;
  event_entry_type pend_data [4];
  logic q_push;
  logic q_full;
  logic q_empty;
  logic q_pop;
  event_entry_type q_in;
  event_entry_type q_out;
  logic [1:0] pick;

  always_comb begin
    pick = 2'd0;
    if (pend[0]) begin
      pick = 2'd0;
    end else if (pend[1]) begin
      pick = 2'd1;
    end else if (pend[2]) begin
      pick = 2'd2;
    end else if (pend[3]) begin
      pick = 2'd3;
    end
  end
  assign q_push = (|pend) && !q_full;
  assign q_in = pend_data[pick];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= '0;
      for (int i = 0; i < 4; i++) begin
        pend_data[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        // A new boot, reset or interrupt event wins over the drain of its slot; an add is refused while slot 3 is pending
        if (q_push && pick == 2'(i)) begin
          pend[i] <= 1'b0;
        end
      end
      if (boot_ev) begin
        pend[0] <= 1'b1;
        pend_data[0] <= boot_entry;
      end
      if (rst_ev) begin
        pend[1] <= 1'b1;
        pend_data[1] <= rst_entry;
      end
      if (nmi_ev) begin
        pend[2] <= 1'b1;
        pend_data[2] <= nmi_entry;
      end
      if (add_entry_i && !pend[3]) begin
        pend[3] <= 1'b1;
        pend_data[3] <= add_data_i;
      end
    end
  end

  event_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_i(q_push),
    .push_data_i(q_in),
    .full_o(q_full),
    .empty_o(q_empty),
    .pop_i(q_pop),
    .pop_data_o(q_out)
  );
  assign queue_full_o = q_full;

  // ---------------------------------------------------------------
  // Event log store
  // ---------------------------------------------------------------
  event_entry_type log_mem [LOG_DEPTH];
  logic [LAW:0] log_count;
  logic [LAW-1:0] clr_ptr;
  logic reserved;

  assign log_full_o = (log_count == (LAW+1)'(LOG_DEPTH));
  // Queue drains only while the log is not being wiped
  assign q_pop = !q_empty && !clearing_o;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reserved <= 1'b0;
      clearing_o <= 1'b0;
      clr_ptr <= '0;
    end else if (clearing_o) begin
      clr_ptr <= clr_ptr + 1'b1;
      if (clr_ptr == LAW'(LOG_DEPTH - 1)) begin
        clearing_o <= 1'b0;
      end
    end else if (clear_i && reserved) begin
      clearing_o <= 1'b1;
      reserved <= 1'b0;
      clr_ptr <= '0;
    end else if (reserve_i) begin
      reserved <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clearing_o) begin
      log_mem[clr_ptr] <= '1;
    end else if (q_pop && !log_full_o) begin
      log_mem[log_count[LAW-1:0]] <= q_out;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      log_count <= '0;
    end else if (clearing_o) begin
      log_count <= '0;
    end else if (q_pop && !log_full_o) begin
      log_count <= log_count + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      forward_valid_o <= 1'b0;
      forward_data_o <= '0;
      read_data_o <= '0;
      entry_count_o <= '0;
    end else begin
      forward_valid_o <= q_pop;
      if (q_pop) begin
        forward_data_o <= q_out;
      end
      entry_count_o <= 16'(log_count);
      read_data_o <= (read_index_i < 16'(log_count)) ? log_mem[read_index_i[LAW-1:0]] : '1;
    end
  end

endmodule : mgmt_event_nmi_reset_logger
`default_nettype wire

/* File: mgmt_event_params.svh */
// Purpose: Offsets, codes and timing counts for the event and interrupt logger
// Assumes: 40 MHz clock
// Notes: Included by the logger top, the assertions and the bench
`ifndef MGMT_EVENT_PARAMS_SVH
`define MGMT_EVENT_PARAMS_SVH

// ---------------------------------------------------------------
// Sensor identities
// ---------------------------------------------------------------
`define PRIMARY_SENSOR_NUM 8'h54
`define BACKUP_SENSOR_NUM 8'h55
`define DISCRETE_READ_TYPE 8'h03
`define OEM_SENSOR_TYPE 8'hC0
`define RESET_SENSOR_NUM 8'hF0
`define NMI_SENSOR_NUM 8'hF1
`define EVENT_ONLY_READ_TYPE 8'h6F
`define RESET_SENSOR_TYPE 8'hCF
`define NMI_SENSOR_TYPE 8'h13

// ---------------------------------------------------------------
// Offsets and cause codes
// ---------------------------------------------------------------
`define OFFSET_SELECTED 8'h01
`define OFFSET_UNSELECTED 8'h00
`define OFFSET_ASSERTED 8'h01
`define BOOT_CAUSE_INSERT 8'h00
`define BOOT_CAUSE_DIP 8'h01
`define BOOT_CAUSE_FLASH_CMD 8'h02
`define BOOT_CAUSE_CTRL_CMD 8'h03
`define BOOT_CAUSE_RECOVERY 8'hFF
`define RESET_TYPE_HARD 8'h00
`define RESET_TYPE_SOFT 8'h01
`define RESET_CAUSE_BUTTON 8'h01
`define RESET_CAUSE_CPU_CMD 8'h02
`define RESET_CAUSE_WATCHDOG_BOOT 8'h03
`define RESET_CAUSE_WATCHDOG 8'h04
`define RESET_CAUSE_COMMAND 8'h05
`define RESET_CAUSE_FILTER 8'h06
`define RESET_CAUSE_CPU_ERR 8'h0A
`define NMI_CAUSE_PRETIMEOUT 8'h01
`define NMI_CAUSE_FILTER 8'h02
`define NMI_CAUSE_CHASSIS 8'h03
`define NMI_CAUSE_CPU_ERR 8'h04
`define NO_DATA_BYTE 8'hFF

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_HZ 40000000
`define NMI_PULSE_MS 30
`define NMI_PULSE_CYCLES ((`CLK_FREQ_HZ / 1000) * `NMI_PULSE_MS)
`define LOG_DEPTH_DEFAULT 256
`define QUEUE_DEPTH_DEFAULT 8

`endif

/* File: mgmt_event_pkg.sv */
// Purpose: Types shared by the event and interrupt logger
// Assumes: Constants come from mgmt_event_params.svh
// Notes: Log entry is sensor, type, offset and two data bytes
package mgmt_event_pkg;

  typedef struct packed {
    logic [7:0] sensor_num;
    logic [7:0] sensor_type;
    logic [7:0] read_type;
    logic [7:0] offset;
    logic [7:0] data2;
    logic [7:0] data3;
  } event_entry_type;

  typedef struct packed {
    logic pretimeout;
    logic filter;
    logic chassis;
    logic cpu_err;
    logic external;
  } nmi_source_type;

  typedef enum logic [1:0] {
    BOOT_PRIMARY,
    BOOT_BACKUP
  } boot_store_type;

endpackage : mgmt_event_pkg

/* File: event_queue.sv */
// Purpose: Small event queue that never overwrites held entries
// Assumes: Writer checks full before pushing
// Notes: Pushes while full are refused, not overwritten
`timescale 1ns/1ps
`default_nettype none
module event_queue #(
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire mgmt_event_pkg::event_entry_type push_data_i,
  output logic full_o,
  output logic empty_o,
  input wire logic pop_i,
  output mgmt_event_pkg::event_entry_type pop_data_o
);
  import mgmt_event_pkg::*;

  localparam int AW = $clog2(DEPTH);

  event_entry_type store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  assign full_o = (count == (AW+1)'(DEPTH));
  assign empty_o = (count == '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign pop_data_o = store[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      store[wr_ptr] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : event_queue
`default_nettype wire

/* File: shelf_sink.sv */
// Purpose: Shelf manager stand-in that takes forwarded events
// Assumes: One entry per forward_valid_o cycle
// Notes: Keeps the last entry and a running count
`timescale 1ns/1ps
`default_nettype none
module shelf_sink (
  input wire logic clk_i,
  input wire logic fwd_valid_i,
  input wire mgmt_event_pkg::event_entry_type fwd_data_i,
  output logic [15:0] rx_count_o = 16'h0000,
  output mgmt_event_pkg::event_entry_type rx_last_o = 48'h000000000000
);
  import mgmt_event_pkg::*;
  // Forwarding goes on even with a full local log
  always @(posedge clk_i) begin
    if (fwd_valid_i) begin
      rx_count_o <= rx_count_o + 16'h0001;
      rx_last_o <= fwd_data_i;
    end
  end
endmodule : shelf_sink
`default_nettype wire

/* File: mgmt_event_nmi_reset_logger_sva.sv */
// Purpose: Port assertions for the event and interrupt logger
// Assumes: Bound to the logger top
// Notes: Pulse width is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_event_params.svh"
module logger_sva #(
  parameter int NMI_CYCLES = 20,
  parameter int LOG_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reset_req_i,
  input wire logic host_reset_o,
  input wire logic [7:0] primary_offset_o,
  input wire logic [7:0] backup_offset_o,
  input wire logic nmi_o,
  input wire logic nmi_chassis_i,
  input wire logic nmi_set_source_i,
  input wire logic nmi_get_source_i,
  input wire mgmt_event_pkg::nmi_source_type nmi_source_o,
  input wire logic forward_valid_o,
  input wire mgmt_event_pkg::event_entry_type forward_data_o,
  input wire logic [15:0] entry_count_o,
  input wire logic log_full_o
);
  import mgmt_event_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [31:0] high_len;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_len <= 32'h0;
    end else begin
      high_len <= nmi_o ? high_len + 32'h1 : 32'h0;
    end
  end
  sequence reset_entry_s;
    forward_valid_o && forward_data_o.sensor_num == `RESET_SENSOR_NUM
      && forward_data_o.offset == `OFFSET_ASSERTED;
  endsequence
  sequence nmi_entry_s;
    forward_valid_o && forward_data_o.sensor_num == `NMI_SENSOR_NUM
      && forward_data_o.offset == `OFFSET_ASSERTED;
  endsequence
  offset_pair_a: assert property ((primary_offset_o == `OFFSET_SELECTED) ?
    (backup_offset_o == `OFFSET_UNSELECTED) : (backup_offset_o == `OFFSET_SELECTED))
    else $error("boot store offsets not paired");
  reset_pulse_a: assert property (reset_req_i |=> host_reset_o ##1 !host_reset_o)
    else $error("host reset pulse wrong");
  reset_logged_a: assert property ($rose(host_reset_o) |-> ##[1:20] reset_entry_s)
    else $error("forced reset entry missing");
  nmi_width_a: assert property ($fell(nmi_o) |-> high_len == NMI_CYCLES)
    else $error("interrupt pulse width wrong");
  nmi_logged_a: assert property ($rose(nmi_o) && !$past(nmi_set_source_i)
    |-> ##[1:20] nmi_entry_s) else $error("forced interrupt entry missing");
  source_latch_a: assert property (nmi_chassis_i |=> nmi_source_o.chassis)
    else $error("chassis source not latched");
  source_clear_a: assert property (nmi_get_source_i && !nmi_chassis_i &&
    !nmi_set_source_i |=> nmi_source_o == 5'h00) else $error("source not cleared");
  count_cap_a: assert property (log_full_o |-> ##[0:2] entry_count_o == 16'(LOG_DEPTH))
    else $error("full log with wrong count");
endmodule : logger_sva
bind mgmt_event_nmi_reset_logger logger_sva #(.NMI_CYCLES(NMI_CYCLES), .LOG_DEPTH(LOG_DEPTH))
  i_sva (.clk_i, .rst_b_i, .reset_req_i, .host_reset_o, .primary_offset_o, .backup_offset_o,
  .nmi_o, .nmi_chassis_i, .nmi_set_source_i, .nmi_get_source_i, .nmi_source_o,
  .forward_valid_o, .forward_data_o, .entry_count_o, .log_full_o);
`default_nettype wire

/* File: mgmt_event_nmi_reset_logger_test.sv */
// Purpose: Self-checking bench for the event and interrupt logger
// Assumes: Pulse width and log depth shortened by parameters
// Notes: Forwarded entries are seen through the shelf stand-in
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_event_params.svh"
module mgmt_event_nmi_reset_logger_test;
  import mgmt_event_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic flag;
    logic [7:0] code;
  } row_type;
  localparam int DEPTH = 8;
  // Kind 0 forced reset (flag soft), 1 store change (flag backup), 2 CPU error reset
  row_type rows [12] = '{
    '{2'h0, 1'h0, 8'h01}, '{2'h0, 1'h1, 8'h02}, '{2'h0, 1'h0, 8'h03},
    '{2'h0, 1'h0, 8'h04}, '{2'h0, 1'h1, 8'h05}, '{2'h0, 1'h0, 8'h06},
    '{2'h2, 1'h0, 8'h0A}, '{2'h1, 1'h1, 8'h00}, '{2'h1, 1'h0, 8'h01},
    '{2'h1, 1'h1, 8'h02}, '{2'h1, 1'h0, 8'h03}, '{2'h1, 1'h1, 8'hFF}};
  logic clk_i = 1'b0, rst_b_i = 1'b0, boot_select_i = 1'b0, boot_change_i = 1'b0;
  logic reset_req_i = 1'b0, reset_soft_i = 1'b0, cpu_internal_error_i = 1'b0;
  logic cpu_err_reset_cfg_i = 1'b0, cpu_err_nmi_cfg_i = 1'b0, nmi_chassis_i = 1'b0;
  logic nmi_filter_i = 1'b0, nmi_pretimeout_i = 1'b0, nmi_set_source_i = 1'b0;
  logic nmi_enable_cmd_i = 1'b0, nmi_enable_val_i = 1'b0, nmi_get_source_i = 1'b0;
  logic add_entry_i = 1'b0, reserve_i = 1'b0, clear_i = 1'b0, pretimeout_nmi_en_i = 1'b1;
  logic [7:0] boot_cause_i = 8'h00, reset_cause_i = 8'h00, primary_offset_o, backup_offset_o;
  logic [15:0] read_index_i = 16'h0000, entry_count_o, rx_count;
  logic host_reset_o, nmi_o, log_full_o, clearing_o, forward_valid_o;
  logic [47:0] exp_msk [DEPTH];
  nmi_source_type nmi_source_o;
  event_entry_type add_data_i = 48'h2A3C0F01A5C3, read_data_o, forward_data_o, rx_last;
  event_entry_type exp_log [DEPTH];
  int err_total = 0, checks = 0, base = 0;
  always #12.5 clk_i = ~clk_i;
  mgmt_event_nmi_reset_logger #(.NMI_CYCLES(20), .LOG_DEPTH(DEPTH)) i_dut (.clk_i, .rst_b_i,
    .boot_select_i, .boot_cause_i, .boot_change_i, .primary_offset_o, .backup_offset_o,
    .reset_req_i, .reset_soft_i, .reset_cause_i, .cpu_internal_error_i, .cpu_err_reset_cfg_i,
    .cpu_err_nmi_cfg_i, .host_reset_o, .nmi_chassis_i, .nmi_filter_i, .nmi_pretimeout_i,
    .pretimeout_nmi_en_i, .nmi_set_source_i, .nmi_enable_cmd_i, .nmi_enable_val_i,
    .nmi_get_source_i, .nmi_source_o, .nmi_o, .add_entry_i, .add_data_i, .reserve_i, .clear_i,
    .read_index_i, .read_data_o, .entry_count_o, .log_full_o, .clearing_o, .queue_full_o(),
    .forward_valid_o, .forward_data_o);
  shelf_sink i_shelf (.clk_i, .fwd_valid_i(forward_valid_o), .fwd_data_i(forward_data_o),
    .rx_count_o(rx_count), .rx_last_o(rx_last));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic look();
    @(negedge clk_i);
  endtask : look
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got,
                     input logic [47:0] msk = 48'hFFFFFFFFFFFF);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp & msk, got & msk);
    end
  endtask : chk
  // A hang counts as a mismatch and ends the run
  task automatic wait_fwd();
    for (int i = 0; i < 60 && rx_count == 16'(base); i++) tick();
    if (rx_count == 16'(base)) begin
      err_total++;
      $display("BAD forwarded entry expected 1 seen 0");
      close_out();
    end
    base = int'(rx_count);
  endtask : wait_fwd
  task automatic wait_nmi_low();
    for (int i = 0; i < 40 && nmi_o !== 1'b0; i++) tick();
    if (nmi_o !== 1'b0) begin
      err_total++;
      $display("BAD nmi_o expected 0 seen %b", nmi_o);
      close_out();
    end
  endtask : wait_nmi_low
  task automatic do_row(input row_type r, input int idx);
    event_entry_type exp;
    logic [47:0] msk;
    msk = (r.kind == 2'h2) ? 48'hFFFFFFFF00FF : 48'hFFFFFFFFFFFF;
    exp = {`RESET_SENSOR_NUM, `RESET_SENSOR_TYPE, `EVENT_ONLY_READ_TYPE, `OFFSET_ASSERTED,
      r.flag ? `RESET_TYPE_SOFT : `RESET_TYPE_HARD, r.code};
    if (r.kind == 2'h1) exp = {r.flag ? `BACKUP_SENSOR_NUM : `PRIMARY_SENSOR_NUM,
      `OEM_SENSOR_TYPE, `DISCRETE_READ_TYPE, `OFFSET_SELECTED, r.code, `NO_DATA_BYTE};
    tick();
    {reset_soft_i, boot_select_i, reset_cause_i, boot_cause_i} <= {r.flag, r.flag, r.code, r.code};
    reset_req_i <= (r.kind == 2'h0);
    boot_change_i <= (r.kind == 2'h1);
    cpu_err_reset_cfg_i <= 1'b1;
    cpu_internal_error_i <= (r.kind == 2'h2);
    tick();
    reset_req_i <= 1'b0;
    boot_change_i <= 1'b0;
    look();
    if (r.kind == 2'h0) chk("host_reset_o", 1'b1, host_reset_o);
    tick(2);
    cpu_internal_error_i <= 1'b0;
    wait_fwd();
    chk("forwarded entry", exp, rx_last, msk);
    if (r.kind == 2'h1) chk("primary_offset_o", r.flag ? 8'h00 : 8'h01, primary_offset_o);
    if (idx < DEPTH) {exp_log[idx], exp_msk[idx]} = {exp, msk};
  endtask : do_row
  task automatic fire(input int k);
    tick();
    case (k)
      0: nmi_pretimeout_i <= 1'b1;
      1: nmi_filter_i <= 1'b1;
      2: nmi_chassis_i <= 1'b1;
      3: cpu_internal_error_i <= 1'b1;
      default: nmi_set_source_i <= 1'b1;
    endcase
    tick();
    {nmi_pretimeout_i, nmi_filter_i, nmi_chassis_i, nmi_set_source_i} <= 4'h0;
    tick(2);
    cpu_internal_error_i <= 1'b0;
    look();
  endtask : fire
  task automatic nmi_enable(input logic val);
    tick();
    nmi_enable_val_i <= val;
    nmi_enable_cmd_i <= 1'b1;
    tick();
    nmi_enable_cmd_i <= 1'b0;
  endtask : nmi_enable
  task automatic src(input logic [4:0] exp);
    look();
    chk("nmi_source_o", exp, nmi_source_o);
    tick();
    nmi_get_source_i <= 1'b1;
    tick();
    nmi_get_source_i <= 1'b0;
    look();
    chk("nmi_source_o cleared", 5'h00, nmi_source_o);
  endtask : src
  task automatic clr_read(input logic [15:0] idx, input logic [47:0] exp,
                          input logic [47:0] msk = 48'hFFFFFFFFFFFF);
    tick();
    read_index_i <= idx;
    tick();
    look();
    chk("read_data_o", exp, read_data_o, msk);
  endtask : clr_read
  initial begin
    tick(20);
    rst_b_i <= 1'b1;
    look();
    chk("primary_offset_o", `OFFSET_SELECTED, primary_offset_o);
    chk("backup_offset_o", `OFFSET_UNSELECTED, backup_offset_o);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      do_row(rows[i], i);
      $display("row %0d done", i);
    end
    look();
    chk("log_full_o", 1'b1, log_full_o);
    chk("entry_count_o", DEPTH, entry_count_o);
    for (int i = 0; i < DEPTH; i++) clr_read(16'(i), exp_log[i], exp_msk[i]);
    $display("log readback done");
    tick();
    cpu_err_reset_cfg_i <= 1'b0;
    cpu_err_nmi_cfg_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      nmi_enable(1'b1);
      fire(k);
      chk("nmi_o", 1'b1, nmi_o);
      wait_fwd();
      chk("interrupt entry", {`NMI_SENSOR_NUM, `NMI_SENSOR_TYPE, `EVENT_ONLY_READ_TYPE,
        `OFFSET_ASSERTED, 8'(k + 1), 8'h00}, rx_last, 48'hFFFFFFFFFF00);
      src(5'h10 >> k);
      wait_nmi_low();
      $display("interrupt trigger %0d done", k);
    end
    fire(2);
    chk("nmi_o disarmed", 1'b0, nmi_o);
    src(5'h04);
    nmi_enable(1'b0);
    fire(1);
    chk("nmi_o masked", 1'b0, nmi_o);
    src(5'h08);
    nmi_enable(1'b1);
    pretimeout_nmi_en_i <= 1'b0;
    fire(0);
    chk("nmi_o no pretimeout", 1'b0, nmi_o);
    fire(4);
    chk("nmi_o set source", 1'b1, nmi_o);
    src(5'h01);
    wait_nmi_low();
    chk("entry count seen", 16'(base), rx_count);
    $display("interrupt refusals done");
    tick();
    clear_i <= 1'b1;
    tick();
    clear_i <= 1'b0;
    tick(2);
    look();
    chk("clearing_o unreserved", 1'b0, clearing_o);
    tick();
    reserve_i <= 1'b1;
    tick();
    reserve_i <= 1'b0;
    clear_i <= 1'b1;
    tick();
    clear_i <= 1'b0;
    add_entry_i <= 1'b1;
    tick();
    add_entry_i <= 1'b0;
    look();
    chk("clearing_o", 1'b1, clearing_o);
    wait_fwd();
    chk("forwarded add", add_data_i, rx_last);
    tick(4);
    look();
    chk("entry_count_o", 16'h0001, entry_count_o);
    clr_read(16'h0000, add_data_i);
    clr_read(16'h0001, 48'hFFFFFFFFFFFF);
    $display("log clear done");
    tick();
    rst_b_i <= 1'b0;
    tick(3);
    rst_b_i <= 1'b1;
    look();
    chk("primary_offset_o", `OFFSET_SELECTED, primary_offset_o);
    fire(2);
    chk("nmi_o after reset", 1'b1, nmi_o);
    wait_fwd();
    wait_nmi_low();
    $display("mid-run reset done");
    close_out();
  end
endmodule : mgmt_event_nmi_reset_logger_test
`default_nettype wire
